// ---- fpm_defines.svh ----
// Constants for the front panel input event mapper
// Assumes a 100 MHz system clock and a plain register port
`ifndef FPM_DEFINES_SVH
`define FPM_DEFINES_SVH
`define FPM_OFS_INPUT0       12'h500
`define FPM_OFS_INPUT1       12'h504
`define FPM_BIT_PIN_STATE    31
`define FPM_BIT_LEVEL_POL    29
`define FPM_BIT_UP_LEVEL     28
`define FPM_BIT_LOC_LEVEL    27
`define FPM_BIT_EDGE_POL     26
`define FPM_BIT_UP_EDGE      25
`define FPM_BIT_LOC_EDGE     24
`define FPM_BUS_HI           23
`define FPM_BUS_LO           16
`define FPM_UP_CODE_HI       15
`define FPM_UP_CODE_LO       8
`define FPM_LOC_CODE_HI      7
`define FPM_LOC_CODE_LO      0
`define FPM_RESET_WORD       32'h0000_0000
`define FPM_CLK_MHZ          100
`define FPM_TICK_US          1
`define FPM_TICK_CYCLES      (`FPM_TICK_US * `FPM_CLK_MHZ)
`endif

// ---- fpm_pkg.sv ----
// Types for the front panel input event mapper
// Assumes nothing beyond the defines header
package fpm_pkg;
	typedef struct packed {
		logic [7:0]  code;
		logic        valid;
	} fpm_slot_t;
endpackage

// ---- fpm_mapper.sv ----
// Front panel input event mapper: two inputs, mapping registers,
// upstream event stream with a two-entry buffer, local event strobe
// Assumes inputs synchronous-ish pins and a single 100 MHz clock
//
// Local design decision: strobed register access.
`include "fpm_defines.svh"
`timescale 1ns/1ps
`default_nettype none
module fpm_mapper
	import fpm_pkg::*;
#(
	parameter int NUM_INPUTS   = 2,
	parameter int TICK_CYCLES  = `FPM_TICK_CYCLES
)
(
	// Clock and reset
	input  wire logic        clk_sys,
	input  wire logic        reset_n,
	// Register port
	input  wire logic [11:0] reg_addr,
	input  wire logic [31:0] reg_wdata,
	input  wire logic        reg_write,
	input  wire logic        reg_read,
	output var  logic [31:0] reg_rdata,
	// Front panel inputs
	input  wire logic [1:0]  panel_in,
	// Upstream event stream
	output var  logic [7:0]  up_event_code,
	output var  logic        up_event_valid,
	input  wire logic        up_event_ready,
	output var  logic [7:0]  up_bus_bits,
	// Local mapping RAM event
	output var  logic [7:0]  local_event_code,
	output var  logic        local_event_valid
);
	// Refuse sizes the fixed two-input logic cannot serve
	if (NUM_INPUTS != 2 || TICK_CYCLES < 1)
	begin : g_bad_params
		$error("fpm_mapper: unsupported parameters");
	end

	localparam int TW = $clog2(TICK_CYCLES + 1);

	typedef struct packed {
		logic [1:0][31:0] map;
		logic [1:0]       sync1;
		logic [1:0]       sync2;
		logic [1:0]       prev;
		logic [TW-1:0]    tick_cnt;
		fpm_slot_t [1:0]  buf_q;
		logic [1:0]       up_pend;
		logic [1:0]       loc_pend;
		logic [31:0]      rdata;
		logic [7:0]       loc_code;
		logic             loc_valid;
		logic [7:0]       bus;
	} fpm_state_t;

	fpm_state_t s_reg;
	fpm_state_t s_next;

	function automatic logic sel_input(input logic [11:0] a, output logic idx);
		idx = (a == `FPM_OFS_INPUT1);
		return (a == `FPM_OFS_INPUT0) || (a == `FPM_OFS_INPUT1);
	endfunction

	logic hit;
	logic hit_idx;
	logic tick;
	logic [1:0] lvl_act;
	logic [1:0] edge_hit;
	logic       pop;
	logic [7:0] bus_acc;
	logic       up_taken;
	logic       loc_taken;
	logic [1:0] up_set;
	logic [1:0] loc_set;

	always_comb
	begin
		s_next = s_reg;
		hit_idx = 1'b0;
		hit = sel_input(reg_addr, hit_idx);
		// Input synchroniser, two stages then edge history
		s_next.sync1 = panel_in;
		s_next.sync2 = s_reg.sync1;
		s_next.prev  = s_reg.sync2;
		// Shared microsecond tick
		tick = (s_reg.tick_cnt == TW'(TICK_CYCLES - 1));
		s_next.tick_cnt = tick ? '0 : s_reg.tick_cnt + TW'(1);
		bus_acc = 8'h00;
		for (int i = 0; i < 2; i++)
		begin
			lvl_act[i] = s_reg.sync2[i] ^ s_reg.map[i][`FPM_BIT_LEVEL_POL];
			edge_hit[i] = s_reg.map[i][`FPM_BIT_EDGE_POL] ? (s_reg.prev[i] & ~s_reg.sync2[i])
				: (~s_reg.prev[i] & s_reg.sync2[i]);
			up_set[i] = (s_reg.map[i][`FPM_BIT_UP_EDGE] && edge_hit[i])
				|| (s_reg.map[i][`FPM_BIT_UP_LEVEL] && lvl_act[i] && tick);
			loc_set[i] = (s_reg.map[i][`FPM_BIT_LOC_EDGE] && edge_hit[i])
				|| (s_reg.map[i][`FPM_BIT_LOC_LEVEL] && lvl_act[i] && tick);
			if (s_reg.sync2[i])
				bus_acc = bus_acc | s_reg.map[i][`FPM_BUS_HI:`FPM_BUS_LO];
		end
		s_next.bus = bus_acc;
		// Two-entry upstream buffer; input 0 wins when both pend
		pop = s_reg.buf_q[0].valid && up_event_ready;
		if (pop)
		begin
			s_next.buf_q[0] = s_reg.buf_q[1];
			s_next.buf_q[1].valid = 1'b0;
		end
		up_taken = 1'b0;
		for (int i = 0; i < 2; i++)
		begin
			if (s_reg.up_pend[i] && !up_taken)
			begin
				if (!s_next.buf_q[0].valid)
				begin
					s_next.buf_q[0].valid = 1'b1;
					s_next.buf_q[0].code = s_reg.map[i][`FPM_UP_CODE_HI:`FPM_UP_CODE_LO];
					s_next.up_pend[i] = 1'b0;
					up_taken = 1'b1;
				end
				else if (!s_next.buf_q[1].valid)
				begin
					s_next.buf_q[1].valid = 1'b1;
					s_next.buf_q[1].code = s_reg.map[i][`FPM_UP_CODE_HI:`FPM_UP_CODE_LO];
					s_next.up_pend[i] = 1'b0;
					up_taken = 1'b1;
				end
			end
		end
		// New event wins over the clear of the old one
		s_next.up_pend = s_next.up_pend | up_set;
		// Local event: one strobe per cycle, input 0 first
		s_next.loc_valid = 1'b0;
		loc_taken = 1'b0;
		for (int i = 0; i < 2; i++)
		begin
			if (s_reg.loc_pend[i] && !loc_taken)
			begin
				s_next.loc_valid = 1'b1;
				s_next.loc_code = s_reg.map[i][`FPM_LOC_CODE_HI:`FPM_LOC_CODE_LO];
				s_next.loc_pend[i] = 1'b0;
				loc_taken = 1'b1;
			end
		end
		s_next.loc_pend = s_next.loc_pend | loc_set;
		// Register writes; state bit is read only
		if (reg_write && hit)
		begin
			s_next.map[hit_idx] = reg_wdata;
			s_next.map[hit_idx][`FPM_BIT_PIN_STATE] = 1'b0;
			s_next.map[hit_idx][30] = 1'b0;
		end
		// Read data valid the cycle after the strobe only
		s_next.rdata = 32'h0000_0000;
		if (reg_read && hit)
		begin
			s_next.rdata = s_reg.map[hit_idx];
			s_next.rdata[`FPM_BIT_PIN_STATE] = s_reg.sync2[hit_idx];
		end
	end

	always_ff @(posedge clk_sys or negedge reset_n)
	begin
		if (!reset_n)
		begin
			s_reg <= '0;
		end
		else
		begin
			s_reg <= s_next;
		end
	end

	assign reg_rdata = s_reg.rdata;
	assign up_event_code = s_reg.buf_q[0].code;
	assign up_event_valid = s_reg.buf_q[0].valid;
	assign up_bus_bits = s_reg.bus;
	assign local_event_code = s_reg.loc_code;
	assign local_event_valid = s_reg.loc_valid;
endmodule
`default_nettype wire

// ---- fpm_mapper_assertions.sv ----
// Port checker for fpm_mapper
// Assumes binding to every fpm_mapper
`timescale 1ns/1ps
`default_nettype none
module fpm_chk(
	input wire logic        clk_sys, reset_n, reg_read, up_event_valid, up_event_ready, local_event_valid,
	input wire logic [11:0] reg_addr,
	input wire logic [31:0] reg_rdata,
	input wire logic [1:0]  panel_in,
	input wire logic [7:0]  up_event_code, up_bus_bits
);
	default clocking @(posedge clk_sys); endclocking
	default disable iff (!reset_n);
	property p_idle; !$past(reg_read) |-> reg_rdata == 32'h0; endproperty
	a_idle: assert property (p_idle) else $error("read data outside slot");
	property p_b30; reg_read |=> reg_rdata[30] == 1'b0; endproperty
	a_b30: assert property (p_b30) else $error("bit 30 set");
	property p_unm; reg_read && reg_addr != 12'h500 && reg_addr != 12'h504 |=> reg_rdata == 32'h0; endproperty
	a_unm: assert property (p_unm) else $error("unmapped read not zero");
	property p_pin; $stable(panel_in)[*3] ##0 reg_read && reg_addr == 12'h500 |=> reg_rdata[31] == $past(panel_in[0]);
	endproperty
	a_pin: assert property (p_pin) else $error("pin state wrong");
	property p_hold; up_event_valid && !up_event_ready |=> up_event_valid && $stable(up_event_code); endproperty
	a_hold: assert property (p_hold) else $error("event dropped");
	property p_drop; $fell(up_event_valid) |-> $past(up_event_ready); endproperty
	a_drop: assert property (p_drop) else $error("valid fell unaccepted");
	property p_bus; (panel_in == 2'h0)[*5] |-> up_bus_bits == 8'h0; endproperty
	a_bus: assert property (p_bus) else $error("bus bits without input");
	property p_rst; $rose(reset_n) |-> !up_event_valid && !local_event_valid; endproperty
	a_rst: assert property (p_rst) else $error("event at reset exit");
endmodule
bind fpm_mapper fpm_chk fpm_chk_inst(.*);
`default_nettype wire

// ---- fpm_sink.sv ----
// Upstream receiver model with commanded stalls
// Assumes the mapper's valid/ready event stream
`timescale 1ns/1ps
`default_nettype none
module fpm_sink(
	input wire logic       clk_sys, reset_n, up_event_valid, stall,
	input wire logic [7:0] up_event_code,
	output logic           up_event_ready,
	output logic [7:0]     got,
	output int             n
);
	always_ff @(posedge clk_sys or negedge reset_n)
		if (!reset_n)
		begin
			up_event_ready <= 0;
			got <= 0;
			n <= 0;
		end
		else
		begin
			up_event_ready <= !stall;
			if (up_event_valid && up_event_ready)
			begin
				got <= up_event_code;
				n <= n + 1;
			end
		end
endmodule
`default_nettype wire

// ---- fpm_mapper_tb.sv ----
// Self-checking bench for fpm_mapper
// Assumes fpm_sink and the bound checker
`timescale 1ns/1ps
`default_nettype none
module fpm_mapper_tb;
	logic        clk_sys = 0, reset_n = 0, reg_write = 0, reg_read = 0, stall = 0, quiet = 0;
	logic [11:0] reg_addr = 0, a;
	logic [31:0] reg_wdata = 0, reg_rdata, r, w;
	logic [1:0]  panel_in = 0;
	logic [7:0]  up_event_code, up_bus_bits, local_event_code, got, lgot, c;
	logic        up_event_valid, up_event_ready, local_event_valid;
	int          fails = 0, num_checks = 0, seed = 62, n, ln = 0, n0, l0;
	fpm_mapper #(.TICK_CYCLES(4)) fpm_mapper_inst(.*);
	fpm_sink fpm_sink_inst(.*);
	initial forever #5 clk_sys = ~clk_sys;
	always @(posedge clk_sys)
	begin
		stall <= !quiet && ($random(seed) & 1);
		if (local_event_valid)
		begin
			lgot <= local_event_code;
			ln <= ln + 1;
		end
	end
	task chk(string s, logic [31:0] e, logic [31:0] g);
		num_checks++;
		if (g !== e)
		begin
			fails++;
			$display("unexpected %s exp %h got %h", s, e, g);
		end
	endtask
	task wt(int k); repeat (k) @(posedge clk_sys); endtask
	task wr(logic [11:0] ad, logic [31:0] d);
		reg_addr <= ad;
		reg_wdata <= d;
		reg_write <= 1;
		wt(1);
		reg_write <= 0;
	endtask
	task rd(logic [11:0] ad);
		reg_addr <= ad;
		reg_read <= 1;
		wt(1);
		reg_read <= 0;
		#1 r = reg_rdata;
		wt(1);
	endtask
	task stop_test;
		$display("checks %0d fails %0d", num_checks, fails);
		if (fails == 0 && num_checks > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask
	initial
	begin
		#20000;
		fails++;
		stop_test;
	end
	initial
	begin
		wt(2);
		reset_n <= 1;
		wt(1);
		rd(12'h500);
		chk("reset", 0, r);
		for (int i = 0; i < 3; i++)
		begin
			w = i ? $random(seed) : 32'hffff_ffff;
			a = i[0] ? 12'h504 : 12'h500;
			wr(a, w);
			rd(a);
			chk("map", {2'h0, w[29:0]}, r);
		end
		wr(12'h508, '1);
		rd(12'h508);
		chk("unmapped", 0, r);
		wr(12'h500, 0);
		wr(12'h504, 0);
		wt(10);
		$display("registers done");
		for (int p = 0; p < 2; p++)
		begin
			c = 8'($random(seed));
			wr(12'h500, {5'h0, p[0], 2'h3, 8'h0, c, ~c});
			n0 = n;
			l0 = ln;
			panel_in[0] <= 1;
			wt(12);
			chk("rise", n0 + 1 - p, n);
			if (!p)
			begin
				chk("local", l0 + 1, ln);
				chk("local code", {24'h0, ~c}, {24'h0, lgot});
			end
			panel_in[0] <= 0;
			wt(12);
			chk("edges", {n0 + 1, c}, {n, got});
		end
		$display("edges done");
		c = 8'($random(seed));
		quiet <= 1;
		wr(12'h504, {8'h38, 8'h0, c, ~c});
		n0 = n;
		l0 = ln;
		wt(40);
		chk("level", 1, n - n0 inside {[9:11]});
		chk("local level", 1, ln - l0 inside {[9:11]});
		chk("level code", c, got);
		panel_in[1] <= 1;
		wt(6);
		n0 = n;
		wt(20);
		chk("inactive", n0, n);
		$display("levels done");
		c = 8'($random(seed));
		wr(12'h504, {8'h0, c, 16'h0});
		wt(2);
		chk("bus", c, up_bus_bits);
		rd(12'h504);
		chk("pin", {8'h80, c, 16'h0}, r);
		$display("bus done");
		stop_test;
	end
endmodule
`default_nettype wire
